// ===== shared/fsp_pkg.sv
// Package of constants and types for the FIFO serial port data path
package fsp_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the APB)
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_FORMAT   = 8'h00;
   localparam logic [7:0]  OFS_TX_PORT  = 8'h04;
   localparam logic [7:0]  OFS_RX_PORT  = 8'h08;
   localparam logic [7:0]  OFS_CONTROL  = 8'h0C;
   localparam logic [7:0]  OFS_STATUS   = 8'h10;

   // ----------------------------------------------------------------
   // Field layout of serial_format_config
   // ----------------------------------------------------------------
   localparam logic [7:0]  FMT_RESET    = 8'h00;
   localparam logic [7:0]  FMT_WR_MASK  = 8'h7B;   // Bits 7 and 2 reserved
   localparam int          FMT_CHR      = 6;
   localparam int          FMT_PE       = 5;
   localparam int          FMT_ODD      = 4;
   localparam int          FMT_STOP     = 3;
   localparam int          FMT_CKS_HI   = 1;
   localparam int          FMT_CKS_LO   = 0;

   // Control and status fields
   localparam int          CTL_TX_ON    = 0;
   localparam int          CTL_RX_ON    = 1;
   localparam int          ST_RX_CNT    = 0;
   localparam int          ST_TX_CNT    = 8;
   localparam int          ST_TX_BUSY   = 16;
   localparam int          ST_RX_BUSY   = 17;
   localparam int          ST_PAR_ERR   = 18;
   localparam int          ST_FRM_ERR   = 19;

   // ----------------------------------------------------------------
   // Timing: prescaler terminal counts and 16x oversampling points
   // ----------------------------------------------------------------
   localparam logic [5:0]  PRE_DIV1     = 6'h00;
   localparam logic [5:0]  PRE_DIV4     = 6'h03;
   localparam logic [5:0]  PRE_DIV16    = 6'h0F;
   localparam logic [5:0]  PRE_DIV64    = 6'h3F;
   localparam logic [3:0]  OS_MID       = 4'h7;
   localparam logic [3:0]  OS_LAST      = 4'hF;
   localparam logic [2:0]  LAST_BIT_8   = 3'h7;
   localparam logic [2:0]  LAST_BIT_7   = 3'h6;

   // Frame states, Gray along start, data, parity, stop
   typedef enum logic [2:0] {
      FR_IDLE  = 3'b000,
      FR_START = 3'b001,
      FR_DATA  = 3'b011,
      FR_PAR   = 3'b010,
      FR_STOP  = 3'b110
   } fsp_frame_t;

   // APB request carried as one bundle
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } fsp_apb_req_t;

endpackage : fsp_pkg

// ===== core/fsp_datapath.sv
// FIFO serial port: frame format, shift registers, FIFOs and APB slave
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fsp_datapath #(
   parameter int         FIFO_DEPTH = 16,
   parameter logic [7:0] BRG_DIV    = 8'h00   // Prescaled pulses per oversample tick, minus 1
) (
   input  wire logic                  clk_sys_in,
   input  wire logic                  reset_n_in,
   input  wire logic                  standby_in,
   input  wire fsp_pkg::fsp_apb_req_t apb_req_in,
   output logic [31:0]                prdata_out,
   output logic                       pready_out,
   output logic                       pslverr_out,
   input  wire logic                  rxd_in,
   output logic                       txd_out
);

   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
   localparam logic [CW-1:0] ONE_CNT  = CW'(1);

   // ----------------------------------------------------------------
   // All state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                  fmt;
      logic                        tx_on;
      logic                        rx_on;
      logic [5:0]                  pre_cnt;
      logic [7:0]                  brg_cnt;
      logic [FIFO_DEPTH-1:0][7:0]  tx_mem;
      logic [PW-1:0]               tx_wp;
      logic [PW-1:0]               tx_rp;
      logic [CW-1:0]               tx_cnt;
      logic [FIFO_DEPTH-1:0][7:0]  rx_mem;
      logic [PW-1:0]               rx_wp;
      logic [PW-1:0]               rx_rp;
      logic [CW-1:0]               rx_cnt;
      fsp_pkg::fsp_frame_t         tx_st;
      logic [7:0]                  tx_sh;
      logic [2:0]                  tx_bit;
      logic [3:0]                  tx_os;
      logic                        tx_stop2;
      logic                        txd;
      logic                        rx_s1;
      logic                        rx_s2;
      fsp_pkg::fsp_frame_t         rx_st;
      logic [7:0]                  rx_sh;
      logic [2:0]                  rx_bit;
      logic [3:0]                  rx_os;
      logic                        par_err;
      logic                        frm_err;
   } fsp_state_t;

   fsp_state_t q;
   fsp_state_t d;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic       acc;
   logic       wr;
   logic       rd;
   logic       hit;
   logic [7:0] ofs;

   assign acc = apb_req_in.psel & apb_req_in.penable;
   assign wr  = acc & apb_req_in.pwrite;
   assign rd  = acc & ~apb_req_in.pwrite;
   assign ofs = apb_req_in.paddr[7:0];
   assign hit = (ofs == fsp_pkg::OFS_FORMAT) | (ofs == fsp_pkg::OFS_TX_PORT)
              | (ofs == fsp_pkg::OFS_RX_PORT) | (ofs == fsp_pkg::OFS_CONTROL)
              | (ofs == fsp_pkg::OFS_STATUS);

   // Zero wait states: every access completes in its first access cycle
   assign pready_out  = 1'b1;
   assign pslverr_out = acc & ~hit;
   assign txd_out     = q.txd;

   // Read mux over registered state only
   always_comb begin
      prdata_out = 32'h0000_0000;
      if (rd) begin
         unique case (ofs)
            fsp_pkg::OFS_FORMAT:  prdata_out[7:0] = q.fmt;
            fsp_pkg::OFS_RX_PORT: prdata_out[7:0] = q.rx_mem[q.rx_rp];
            fsp_pkg::OFS_CONTROL: begin
               prdata_out[fsp_pkg::CTL_TX_ON] = q.tx_on;
               prdata_out[fsp_pkg::CTL_RX_ON] = q.rx_on;
            end
            fsp_pkg::OFS_STATUS: begin
               prdata_out[fsp_pkg::ST_RX_CNT +: CW] = q.rx_cnt;
               prdata_out[fsp_pkg::ST_TX_CNT +: CW] = q.tx_cnt;
               prdata_out[fsp_pkg::ST_TX_BUSY]      = (q.tx_st != fsp_pkg::FR_IDLE);
               prdata_out[fsp_pkg::ST_RX_BUSY]      = (q.rx_st != fsp_pkg::FR_IDLE);
               prdata_out[fsp_pkg::ST_PAR_ERR]      = q.par_err;
               prdata_out[fsp_pkg::ST_FRM_ERR]      = q.frm_err;
            end
            default: prdata_out = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic       pre_en;
   logic       tick;
   logic [5:0] pre_lim;
   logic [2:0] last_bit;
   logic       tx_push;
   logic       tx_pop;
   logic       rx_push;
   logic       rx_pop;
   logic       rx_mid;
   logic       rx_end;
   logic       tx_end;

   always_comb begin
      d        = q;
      tx_pop   = 1'b0;
      rx_push  = 1'b0;

      // Prescaler selected by the two clock select bits
      unique case (q.fmt[fsp_pkg::FMT_CKS_HI:fsp_pkg::FMT_CKS_LO])
         2'b00:   pre_lim = fsp_pkg::PRE_DIV1;
         2'b01:   pre_lim = fsp_pkg::PRE_DIV4;
         2'b10:   pre_lim = fsp_pkg::PRE_DIV16;
         default: pre_lim = fsp_pkg::PRE_DIV64;
      endcase
      pre_en    = (q.pre_cnt >= pre_lim);
      d.pre_cnt = pre_en ? 6'h00 : q.pre_cnt + 6'h01;
      // Bit-rate divider turns prescaled pulses into 16x oversample ticks
      tick = pre_en & (q.brg_cnt >= BRG_DIV);
      if (pre_en) begin
         d.brg_cnt = tick ? 8'h00 : q.brg_cnt + 8'h01;
      end

      last_bit = q.fmt[fsp_pkg::FMT_CHR] ? fsp_pkg::LAST_BIT_7 : fsp_pkg::LAST_BIT_8;

      // Register writes; the format register is masked so reserved bits stay zero
      tx_push = wr & (ofs == fsp_pkg::OFS_TX_PORT) & (q.tx_cnt != FULL_CNT);
      rx_pop  = rd & (ofs == fsp_pkg::OFS_RX_PORT) & (q.rx_cnt != '0);
      if (wr & (ofs == fsp_pkg::OFS_FORMAT)) begin
         d.fmt = apb_req_in.pwdata[7:0] & fsp_pkg::FMT_WR_MASK;
      end
      if (wr & (ofs == fsp_pkg::OFS_CONTROL)) begin
         d.tx_on = apb_req_in.pwdata[fsp_pkg::CTL_TX_ON];
         d.rx_on = apb_req_in.pwdata[fsp_pkg::CTL_RX_ON];
      end
      // Error flags clear by writing one; a set below overrides the clear
      if (wr & (ofs == fsp_pkg::OFS_STATUS)) begin
         if (apb_req_in.pwdata[fsp_pkg::ST_PAR_ERR]) d.par_err = 1'b0;
         if (apb_req_in.pwdata[fsp_pkg::ST_FRM_ERR]) d.frm_err = 1'b0;
      end
      if (standby_in) begin
         d.fmt = fsp_pkg::FMT_RESET;
      end

      // Transmitter: line idles high, reloads whenever shifter empties and tx_on is set
      tx_end = tick & (q.tx_os == fsp_pkg::OS_LAST);
      if (tick) d.tx_os = q.tx_os + 4'h1;
      unique case (q.tx_st)
         fsp_pkg::FR_IDLE: begin
            d.txd = 1'b1;
            if (q.tx_on & (q.tx_cnt != '0)) begin
               tx_pop   = 1'b1;
               d.tx_sh  = q.tx_mem[q.tx_rp];
               if (q.fmt[fsp_pkg::FMT_CHR]) d.tx_sh[7] = 1'b0;
               d.tx_st  = fsp_pkg::FR_START;
               d.tx_os  = 4'h0;
               d.tx_bit = 3'h0;
               d.tx_stop2 = 1'b0;
               d.txd    = 1'b0;
            end
         end
         fsp_pkg::FR_START: begin
            if (tx_end) begin
               d.tx_st = fsp_pkg::FR_DATA;
               d.txd   = q.tx_sh[0];
            end
         end
         fsp_pkg::FR_DATA: begin
            if (tx_end) begin
               if (q.tx_bit == last_bit) begin
                  if (q.fmt[fsp_pkg::FMT_PE]) begin
                     d.tx_st = fsp_pkg::FR_PAR;
                     d.txd   = (^q.tx_sh) ^ q.fmt[fsp_pkg::FMT_ODD];
                  end else begin
                     d.tx_st = fsp_pkg::FR_STOP;
                     d.txd   = 1'b1;
                  end
               end else begin
                  d.tx_bit = q.tx_bit + 3'h1;
                  d.txd    = q.tx_sh[q.tx_bit + 3'h1];
               end
            end
         end
         fsp_pkg::FR_PAR: begin
            if (tx_end) begin
               d.tx_st = fsp_pkg::FR_STOP;
               d.txd   = 1'b1;
            end
         end
         fsp_pkg::FR_STOP: begin
            d.txd = 1'b1;
            if (tx_end) begin
               if (q.fmt[fsp_pkg::FMT_STOP] & ~q.tx_stop2) begin
                  d.tx_stop2 = 1'b1;
               end else begin
                  d.tx_st = fsp_pkg::FR_IDLE;
               end
            end
         end
         default: begin
            d.tx_st = fsp_pkg::FR_IDLE;
            d.txd   = 1'b1;
         end
      endcase

      // Receiver: only the synchronised copy of the line is examined
      d.rx_s1 = rxd_in;
      d.rx_s2 = q.rx_s1;
      if (tick) d.rx_os = q.rx_os + 4'h1;
      rx_mid = tick & (q.rx_os == fsp_pkg::OS_MID);
      rx_end = tick & (q.rx_os == fsp_pkg::OS_LAST);
      unique case (q.rx_st)
         fsp_pkg::FR_IDLE: begin
            if (q.rx_on & ~q.rx_s2) begin
               d.rx_st = fsp_pkg::FR_START;
               d.rx_os = 4'h0;
               d.rx_sh = 8'h00;
               d.rx_bit = 3'h0;
            end
         end
         fsp_pkg::FR_START: begin
            // A start bit that is high again at mid-bit was a glitch
            if (rx_mid) begin
               d.rx_os = 4'h0;
               d.rx_st = q.rx_s2 ? fsp_pkg::FR_IDLE : fsp_pkg::FR_DATA;
            end
         end
         fsp_pkg::FR_DATA: begin
            // Counter restarted at mid-bit, so the wrap is the next bit centre
            if (rx_end) begin
               d.rx_sh[q.rx_bit] = q.rx_s2;
               if (q.rx_bit == last_bit) begin
                  d.rx_st = q.fmt[fsp_pkg::FMT_PE] ? fsp_pkg::FR_PAR : fsp_pkg::FR_STOP;
               end else begin
                  d.rx_bit = q.rx_bit + 3'h1;
               end
            end
         end
         fsp_pkg::FR_PAR: begin
            if (rx_end) begin
               d.rx_st = fsp_pkg::FR_STOP;
               if ((^q.rx_sh) ^ q.rx_s2 ^ q.fmt[fsp_pkg::FMT_ODD]) begin
                  d.par_err = 1'b1;
               end
            end
         end
         fsp_pkg::FR_STOP: begin
            // Only the first stop bit is sampled; a second one is not awaited
            if (rx_end) begin
               d.rx_st = fsp_pkg::FR_IDLE;
               if (~q.rx_s2) d.frm_err = 1'b1;
               rx_push = (q.rx_cnt != FULL_CNT) | rx_pop;
            end
         end
         default: d.rx_st = fsp_pkg::FR_IDLE;
      endcase

      // FIFO bookkeeping
      if (tx_push) begin
         d.tx_mem[q.tx_wp] = apb_req_in.pwdata[7:0];
         d.tx_wp = q.tx_wp + PW'(1);
      end
      if (tx_pop) d.tx_rp = q.tx_rp + PW'(1);
      if (tx_push & ~tx_pop) d.tx_cnt = q.tx_cnt + ONE_CNT;
      if (tx_pop & ~tx_push) d.tx_cnt = q.tx_cnt - ONE_CNT;
      if (rx_push) begin
         d.rx_mem[q.rx_wp] = q.rx_sh;
         d.rx_wp = q.rx_wp + PW'(1);
      end
      if (rx_pop) d.rx_rp = q.rx_rp + PW'(1);
      if (rx_push & ~rx_pop) d.rx_cnt = q.rx_cnt + ONE_CNT;
      if (rx_pop & ~rx_push) d.rx_cnt = q.rx_cnt - ONE_CNT;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q       <= '0;
         q.fmt   <= fsp_pkg::FMT_RESET;
         q.tx_st <= fsp_pkg::FR_IDLE;
         q.rx_st <= fsp_pkg::FR_IDLE;
         q.txd   <= 1'b1;
         q.rx_s1 <= 1'b1;
         q.rx_s2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   a_fmt_reserved_zero: assert property (
      (q.fmt & ~fsp_pkg::FMT_WR_MASK) == 8'h00) else $error("reserved format bit set");
   a_fmt_standby_clr: assert property (
      standby_in |=> q.fmt == fsp_pkg::FMT_RESET) else $error("standby left format set");
   a_tx_idle_high: assert property (
      (q.tx_st == fsp_pkg::FR_IDLE) && $past(q.tx_st == fsp_pkg::FR_IDLE) |-> txd_out)
      else $error("idle line not high");
   a_tx_start_low: assert property (
      q.tx_st == fsp_pkg::FR_START |-> !txd_out) else $error("start bit not low");
   a_tx_stop_high: assert property (
      q.tx_st == fsp_pkg::FR_STOP |-> txd_out) else $error("stop bit not high");
   a_tx_parity_val: assert property (
      q.tx_st == fsp_pkg::FR_PAR |-> txd_out == ((^q.tx_sh) ^ q.fmt[fsp_pkg::FMT_ODD]))
      else $error("wrong parity bit");
   a_tx_seven_bit: assert property (
      $rose(q.tx_st == fsp_pkg::FR_START) && q.fmt[fsp_pkg::FMT_CHR] |-> !q.tx_sh[7])
      else $error("bit 7 kept in seven-bit mode");
   a_tx_gate_off: assert property (
      !q.tx_on && q.tx_st == fsp_pkg::FR_IDLE |=> q.tx_st == fsp_pkg::FR_IDLE)
      else $error("transmitter started while off");
   a_tx_full_drop: assert property (
      wr && ofs == fsp_pkg::OFS_TX_PORT && q.tx_cnt == FULL_CNT
      |=> q.tx_cnt == FULL_CNT || q.tx_cnt == FULL_CNT - ONE_CNT)
      else $error("write to full transmit FIFO took effect");
   a_rx_full_drop: assert property (
      rx_end && q.rx_st == fsp_pkg::FR_STOP && q.rx_cnt == FULL_CNT && !rx_pop
      |=> q.rx_cnt == FULL_CNT && q.rx_wp == $past(q.rx_wp))
      else $error("character overwrote full receive FIFO");
   a_rx_push_one: assert property (
      rx_end && q.rx_st == fsp_pkg::FR_STOP && q.rx_cnt != FULL_CNT && !rx_pop
      |=> q.rx_cnt == $past(q.rx_cnt) + ONE_CNT) else $error("character not stored");
   a_rx_off_idle: assert property (
      !q.rx_on && q.rx_st == fsp_pkg::FR_IDLE |=> q.rx_st == fsp_pkg::FR_IDLE)
      else $error("receiver started while off");
   a_pre_undiv: assert property (
      q.fmt[fsp_pkg::FMT_CKS_HI:fsp_pkg::FMT_CKS_LO] == 2'b00 |-> pre_en)
      else $error("undivided prescale missing pulse");
   // A wrong terminal count would let two pulses run back to back
   a_pre_div4_gap: assert property (
      pre_en && q.fmt[fsp_pkg::FMT_CKS_HI:fsp_pkg::FMT_CKS_LO] == 2'b01
      ##1 q.fmt[fsp_pkg::FMT_CKS_HI:fsp_pkg::FMT_CKS_LO] == 2'b01 |-> !pre_en)
      else $error("divide-by-four prescale pulsed twice running");

   c_tx_frame: cover property (q.tx_st == fsp_pkg::FR_STOP ##1 q.tx_st == fsp_pkg::FR_IDLE);
   c_rx_store: cover property (rx_push);
   c_rx_parity_err: cover property ($rose(q.par_err));
   c_tx_full: cover property (q.tx_cnt == FULL_CNT);

endmodule : fsp_datapath

`default_nettype wire

// ===== verification/fsp_remote.sv
// Remote serial transceiver model facing the serial pins
`timescale 1ns/1ps
`default_nettype none

module fsp_remote (
   input  wire logic        clk_in,
   input  wire logic        txd_in,
   input  wire logic [7:0]  fmt_in,
   input  wire logic [15:0] bit_in,
   output logic             rxd_out,
   output logic             got_out,
   output logic [9:0]       seen_out,
   output logic [15:0]      span_out
);
   int         cyc  = 0;
   int         last = 0;
   logic [7:0] d;
   logic       ok;

   // ------
   // Receive and send
   // ------
   // Line idles high, as its pull-up would hold it
   initial rxd_out = 1'b1;
   initial got_out = 1'b0;
   always @(posedge clk_in) cyc <= cyc + 1;

   // Decode one frame per falling edge, sampling at bit centres
   always begin
      @(negedge txd_in);
      span_out <= 16'(cyc - last);
      last = cyc;
      d = 8'h00;
      repeat (bit_in / 2) @(posedge clk_in);
      for (int i = 0; i < (fmt_in[fsp_pkg::FMT_CHR] ? 7 : 8); i++) begin
         repeat (bit_in) @(posedge clk_in);
         d[i] = txd_in;
      end
      ok = 1'b1;
      if (fmt_in[fsp_pkg::FMT_PE]) begin
         repeat (bit_in) @(posedge clk_in);
         ok = (^d ^ txd_in) == fmt_in[fsp_pkg::FMT_ODD];
      end
      repeat (bit_in) @(posedge clk_in);
      seen_out <= {txd_in, ok, d};
      got_out  <= 1'b1;
      @(posedge clk_in);
      got_out  <= 1'b0;
   end

   // One bit on the line for a whole bit period
   task automatic put(input logic b);
      @(posedge clk_in);
      rxd_out <= b;
      repeat (bit_in - 1) @(posedge clk_in);
   endtask : put

   // One frame, low start and LSB first; flip spoils the parity bit
   task automatic send(input logic [7:0] b, input logic flip);
      logic [7:0] s;
      s = fmt_in[fsp_pkg::FMT_CHR] ? {1'b0, b[6:0]} : b;
      put(1'b0);
      for (int k = 0; k < (fmt_in[fsp_pkg::FMT_CHR] ? 7 : 8); k++) put(s[k]);
      if (fmt_in[fsp_pkg::FMT_PE]) put(^s ^ fmt_in[fsp_pkg::FMT_ODD] ^ flip);
      // Single stop always, so a second stop slot may carry the next start
      put(1'b1);
   endtask : send
endmodule : fsp_remote

`default_nettype wire

// ===== verification/fsp_datapath_tb.sv
// Self-checking bench for the FIFO serial port data path
`timescale 1ns/1ps
`default_nettype none

module fsp_datapath_tb;
   logic                  clk_sys;
   logic                  reset_n;
   logic                  standby;
   fsp_pkg::fsp_apb_req_t req;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  rxd;
   logic                  txd;
   logic                  got;
   logic [9:0]            seen;
   logic [15:0]           span;
   logic [7:0]            fmt = 8'h00;
   logic [15:0]           bitc = 16'h0010;
   logic [32:0]           rd_q[$];
   logic [31:0]           mk_q[$];
   logic [25:0]           tx_q[$];
   logic [7:0]            v[17];
   logic [7:0]            modes[7] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h78, 8'h28, 8'h10};
   logic [31:0]           m;
   logic [32:0]           e;
   logic [25:0]           t;
   int                    bad_count = 0;
   int                    check_count = 0;

   fsp_datapath #(.FIFO_DEPTH(16), .BRG_DIV(8'h00)) i_fsp_datapath (
      .clk_sys_in(clk_sys), .reset_n_in(reset_n), .standby_in(standby), .apb_req_in(req),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
      .txd_out(txd));
   fsp_remote i_fsp_remote (.clk_in(clk_sys), .txd_in(txd), .fmt_in(fmt), .bit_in(bitc),
      .rxd_out(rxd), .got_out(got), .seen_out(seen), .span_out(span));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [33:0] sv, input logic [33:0] ev, input string what);
      check_count++;
      if (sv !== ev) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, ev, sv);
      end
   endtask : check

   // One APB transfer; a read leaves its note in the queues first
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] mk, input logic [32:0] ex);
      if (!w) begin
         rd_q.push_back(ex);
         mk_q.push_back(mk);
      end
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      @(posedge clk_sys);
      for (int k = 0; k < 50 && pready !== 1'b1; k++) @(posedge clk_sys);
      if (pready !== 1'b1) bad_count++;
      req <= '0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 33'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [32:0] ex);
      apb(1'b0, a, 32'h0, mk, ex);
   endtask : rd

   // Note the frame the far side should see, then queue the byte
   task automatic tx(input logic [7:0] b, input logic [15:0] s);
      tx_q.push_back({s, 2'b11, fmt[fsp_pkg::FMT_CHR] ? {1'b0, b[6:0]} : b});
      wr(fsp_pkg::OFS_TX_PORT, {24'h0, b});
   endtask : tx

   // Bounded wait for the queue to drain, then let the stop bits finish
   task automatic wait_tx;
      for (int k = 0; k < 60000 && tx_q.size() != 0; k++) @(posedge clk_sys);
      if (tx_q.size() != 0) bad_count++;
      repeat (2 * bitc) @(posedge clk_sys);
   endtask : wait_tx

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   // Read data against the oldest note; masks hide undocumented bits
   always @(posedge clk_sys) begin
      if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
         m = mk_q.pop_front();
         e = rd_q.pop_front();
         check({pslverr, prdata & m}, {e[32], e[31:0] & m}, "read");
      end
   end

   // Frames at the far side; a zero span note means the gap is not timed
   always @(posedge clk_sys) begin
      if (got === 1'b1) begin
         t = (tx_q.size() != 0) ? tx_q.pop_front() : '1;
         check({t[25:10] ? span : 16'h0, seen}, t, "frame");
      end
   end

   // Watchdog set well past the slowest prescaler run
   initial begin
      #600us;
      bad_count++;
      wrap_up();
   end

   // ------
   // Scenarios
   // ------
   initial begin
      req = '0;
      standby = 1'b0;
      reset_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      void'($urandom(87));
      // Reset value, reserved bits, write-only port, unmapped offset, standby
      rd(fsp_pkg::OFS_FORMAT, 32'hFF, 33'h0);
      wr(fsp_pkg::OFS_FORMAT, 32'hFF);
      rd(fsp_pkg::OFS_FORMAT, 32'hFF, 33'h7B);
      rd(fsp_pkg::OFS_TX_PORT, 32'hFFFFFFFF, 33'h0);
      rd(8'h40, 32'h0, {1'b1, 32'h0});
      @(posedge clk_sys);
      standby <= 1'b1;
      @(posedge clk_sys);
      standby <= 1'b0;
      rd(fsp_pkg::OFS_FORMAT, 32'hFF, 33'h0);
      // Transmitter off: sixteen bytes wait, the seventeenth is dropped
      for (int k = 0; k < 17; k++) begin
         v[k] = 8'($urandom);
         wr(fsp_pkg::OFS_TX_PORT, {24'h0, v[k]});
      end
      rd(fsp_pkg::OFS_STATUS, 32'h1F00, 33'h1000);
      check(txd, 1'b1, "idle line");
      for (int k = 0; k < 16; k++) tx_q.push_back({k ? 16'h00A1 : 16'h0, 2'b11, v[k]});
      wr(fsp_pkg::OFS_CONTROL, 32'h3);
      wait_tx();
      // Seven framing modes, two back-to-back frames in each direction at once
      foreach (modes[j]) begin
         fmt = modes[j];
         wr(fsp_pkg::OFS_FORMAT, {24'h0, fmt});
         v[0] = 8'($urandom);
         v[1] = 8'($urandom);
         tx(v[0], 16'h0);
         tx(v[1], 16'(16 * (2 + (fmt[6] ? 7 : 8) + fmt[5] + fmt[3]) + 1));
         i_fsp_remote.send(v[0], 1'b0);
         i_fsp_remote.send(v[1], 1'b0);
         for (int k = 0; k < 2; k++) rd(fsp_pkg::OFS_RX_PORT, 32'hFF,
            {25'h0, v[k][7] & ~fmt[6], v[k][6:0]});
         wait_tx();
      end
      // Wrong parity: frame still stored, sticky flag raised
      fmt = 8'h20;
      wr(fsp_pkg::OFS_FORMAT, 32'h20);
      i_fsp_remote.send(8'hA5, 1'b1);
      rd(fsp_pkg::OFS_STATUS, 32'hC0000, 33'h40000);
      rd(fsp_pkg::OFS_RX_PORT, 32'hFF, 33'hA5);
      // Writing one clears the sticky parity flag
      wr(fsp_pkg::OFS_STATUS, 32'h40000);
      rd(fsp_pkg::OFS_STATUS, 32'hC0000, 33'h0);
      // Receiver off: a frame is ignored, and so is a write to the read port
      wr(fsp_pkg::OFS_CONTROL, 32'h1);
      wr(fsp_pkg::OFS_RX_PORT, 32'h5A);
      i_fsp_remote.send(8'h3C, 1'b0);
      rd(fsp_pkg::OFS_STATUS, 32'h1F, 33'h0);
      wr(fsp_pkg::OFS_CONTROL, 32'h3);
      // Seventeen frames into an empty receive FIFO: the last is lost
      for (int k = 0; k < 17; k++) begin
         v[k] = 8'($urandom);
         i_fsp_remote.send(v[k], 1'b0);
      end
      rd(fsp_pkg::OFS_STATUS, 32'h1F, 33'h10);
      for (int k = 0; k < 16; k++) rd(fsp_pkg::OFS_RX_PORT, 32'hFF, {25'h0, v[k]});
      // Prescaler codes 01, 10, 11 stretch the bit by 4, 16 and 64
      for (int s = 1; s < 4; s++) begin
         fmt = 8'(s);
         bitc = 16'(16 << (2 * s));
         wr(fsp_pkg::OFS_FORMAT, {24'h0, fmt});
         tx(8'h35, 16'h0);
         wait_tx();
      end
      wrap_up();
   end
endmodule : fsp_datapath_tb

`default_nettype wire
